// ---- exc_entry_defines.svh ----
// Offsets, field positions, reset values and vector defaults of the exception entry block
`ifndef EXC_ENTRY_DEFINES_SVH
`define EXC_ENTRY_DEFINES_SVH

// Register byte offsets
`define OFS_STATUS 8'h00
`define OFS_ESTATUS 8'h04
`define OFS_RET_ADDR 8'h08
`define OFS_PTE_ADDR 8'h0c
`define OFS_TLB_MISC 8'h10
`define OFS_CAUSE 8'h14
`define OFS_BAD_ADDR 8'h18

// Status field positions
`define ST_PIE 0
`define ST_USER 1
`define ST_EH 2

// Translation flag positions
`define TM_DATA 0
`define TM_DBL 1
`define TM_ACCESS_RIGHTS_FLAG 2
`define TM_BAD 3

// Page number field in the page-entry address register
`define PTE_VPN_LO 2
`define PTE_VPN_HI 21
`define VA_VPN_LO 12

// Reset values
`define STATUS_RST 3'h0
`define TLB_MISC_RST 4'h0
`define WORD_RST 32'h0000_0000

// Default handler addresses
`define GEN_VEC_DEF 32'h0000_0020
`define FAST_VEC_DEF 32'h0000_0100

`endif

// ---- exc_entry_pkg.sv ----
// Types shared by the exception entry block and its neighbours
package exc_entry_pkg;

	// Kind of access behind a request
	typedef enum logic [2:0] {
		ACC_NONE = 3'h0,
		ACC_FETCH = 3'h1,
		ACC_LOAD = 3'h2,
		ACC_STORE = 3'h3,
		ACC_LINE_INV = 3'h4,
		ACC_LINE_WB = 3'h5,
		ACC_IDX_INV = 3'h6,
		ACC_IDX_WB = 3'h7
	} access_t;

	// Exception kind latched at acceptance
	typedef enum logic [2:0] {
		K_PIPE = 3'h0,
		K_FAST = 3'h1,
		K_DBL = 3'h2,
		K_ACCESS_RIGHTS_FLAG = 3'h3,
		K_MPU = 3'h4
	} kind_t;

	// Entry sequencer, Gray from IDLE through SAVE to VECT
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SAVE = 2'h1,
		ST_VECT = 2'h3
	} state_t;

	// One request from pipeline and lookup units
	typedef struct packed {
		logic valid;
		logic pipe_exc;
		logic [4:0] pipe_cause;
		access_t acc;
		logic [31:0] vaddr;
		logic [31:0] next_pc;
		logic tlb_match;
		logic tlb_access_rights_flag_ok;
		logic mpu_match;
		logic mpu_access_rights_flag_ok;
	} exc_req_t;

	// Cause codes supplied by the core
	typedef struct packed {
		logic [4:0] fast_i;
		logic [4:0] fast_d;
		logic [4:0] dbl_i;
		logic [4:0] dbl_d;
		logic [4:0] access_rights_flag_x;
		logic [4:0] access_rights_flag_r;
		logic [4:0] access_rights_flag_w;
		logic [4:0] mpu_i;
		logic [4:0] mpu_d;
	} cause_codes_t;

	// All state of the entry block
	typedef struct packed {
		state_t st;
		kind_t kind;
		logic data_side;
		logic [31:0] lat_vaddr;
		logic [31:0] lat_pc;
		logic [4:0] lat_cause;
		logic [2:0] status;
		logic [2:0] estatus;
		logic [31:0] ret_addr;
		logic [19:0] virtual_page_number;
		logic [3:0] tlb_misc;
		logic [4:0] cause;
		logic [31:0] bad_addr;
		logic redir;
		logic [31:0] redir_pc;
		logic [31:0] rdata;
	} entry_state_t;

endpackage : exc_entry_pkg

// ---- exc_entry.sv ----
// Exception detection and hardware entry sequence of the core
`timescale 1ns/10ps
`include "exc_entry_defines.svh"

module exc_entry #(
	parameter bit MMU_ON = 1'b1,
	parameter bit MPU_ON = 1'b0,
	parameter logic [31:0] GEN_VEC = `GEN_VEC_DEF,
	parameter logic [31:0] FAST_VEC = `FAST_VEC_DEF
) (
	// Clock, enable, reset
	input wire logic mclk_in,
	input wire logic ce_in,
	input wire logic rst_b_in,
	// Register port
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rd_data_out,
	// Exception requests
	input exc_entry_pkg::exc_req_t req_in,
	input exc_entry_pkg::cause_codes_t codes_in,
	output logic entry_ready_out,
	// Results toward the core
	output logic redirect_valid_out,
	output logic [31:0] redirect_pc_out,
	output logic [2:0] status_out,
	output logic [31:0] ret_addr_out,
	output logic [4:0] cause_out
);

	exc_entry_pkg::entry_state_t cur;
	exc_entry_pkg::entry_state_t next_cur;
	logic eh;
	logic fetch;
	logic load;
	logic store;
	logic data_tr;
	logic mem_acc;
	logic miss;
	logic access_rights_flag;
	logic mpu_viol;
	logic accept;
	exc_entry_pkg::kind_t found;
	logic [4:0] found_cause;
	logic save_regs;

	// Access classification
	assign eh = cur.status[`ST_EH];
	assign fetch = req_in.acc == exc_entry_pkg::ACC_FETCH;
	assign load = req_in.acc == exc_entry_pkg::ACC_LOAD;
	assign store = req_in.acc == exc_entry_pkg::ACC_STORE;
	// Index forms never translate, so only line forms join here
	assign data_tr = load | store
		| (req_in.acc == exc_entry_pkg::ACC_LINE_INV)
		| (req_in.acc == exc_entry_pkg::ACC_LINE_WB);
	assign mem_acc = fetch | data_tr;

	// Lookup faults
	assign miss = MMU_ON & mem_acc & ~req_in.tlb_match;
	// Cache management falls outside fetch, load, store
	assign access_rights_flag = MMU_ON & req_in.tlb_match
		& ~req_in.tlb_access_rights_flag_ok
		& (fetch | load | store);
	// No matching region counts as a violation too
	assign mpu_viol = MPU_ON & ~MMU_ON & mem_acc
		& (~req_in.mpu_match
		| ~req_in.mpu_access_rights_flag_ok);

	// Pick kind and code; pipeline faults are older, so win
	always_comb begin
		found = exc_entry_pkg::K_PIPE;
		found_cause = req_in.pipe_cause;
		if (req_in.pipe_exc) begin
			found = exc_entry_pkg::K_PIPE;
		end else if (miss && eh) begin
			found = exc_entry_pkg::K_DBL;
			found_cause = fetch ? codes_in.dbl_i
				: codes_in.dbl_d;
		end else if (miss) begin
			found = exc_entry_pkg::K_FAST;
			found_cause = fetch ? codes_in.fast_i
				: codes_in.fast_d;
		end else if (access_rights_flag) begin
			found = exc_entry_pkg::K_ACCESS_RIGHTS_FLAG;
			found_cause = fetch ? codes_in.access_rights_flag_x
				: load ? codes_in.access_rights_flag_r
				: codes_in.access_rights_flag_w;
		end else if (mpu_viol) begin
			found = exc_entry_pkg::K_MPU;
			found_cause = fetch ? codes_in.mpu_i
				: codes_in.mpu_d;
		end
	end

	// Only one entry in flight at a time
	assign entry_ready_out = cur.st == exc_entry_pkg::ST_IDLE;
	assign accept = entry_ready_out & req_in.valid
		& (req_in.pipe_exc | miss | access_rights_flag | mpu_viol);

	// Saved copies stay put while a nested entry runs, in the translation build only
	assign save_regs = ~MMU_ON | ~eh;

	// Next state: software writes first, entry actions override
	always_comb begin
		next_cur = cur;
		next_cur.redir = 1'b0;
		next_cur.rdata = `WORD_RST;
		if (rd_in) begin
			unique case (addr_in)
				`OFS_STATUS: next_cur.rdata = {29'h0, cur.status};
				`OFS_ESTATUS: next_cur.rdata = {29'h0, cur.estatus};
				`OFS_RET_ADDR: next_cur.rdata = cur.ret_addr;
				`OFS_PTE_ADDR: next_cur.rdata = {10'h0, cur.virtual_page_number, 2'h0};
				`OFS_TLB_MISC: next_cur.rdata = {28'h0, cur.tlb_misc};
				`OFS_CAUSE: next_cur.rdata = {27'h0, cur.cause};
				`OFS_BAD_ADDR: next_cur.rdata = cur.bad_addr;
				default: next_cur.rdata = `WORD_RST;
			endcase
		end
		if (wr_in) begin
			unique case (addr_in)
				`OFS_STATUS: next_cur.status = wr_data_in[2:0];
				`OFS_ESTATUS: next_cur.estatus = wr_data_in[2:0];
				`OFS_RET_ADDR: next_cur.ret_addr = wr_data_in;
				`OFS_PTE_ADDR: begin
					next_cur.virtual_page_number = wr_data_in[`PTE_VPN_HI:`PTE_VPN_LO];
				end
				`OFS_TLB_MISC: next_cur.tlb_misc = wr_data_in[3:0];
				default: begin
				end
			endcase
		end
		unique case (cur.st)
			exc_entry_pkg::ST_IDLE: begin
				if (accept) begin
					next_cur.kind = found;
					next_cur.data_side = ~fetch;
					next_cur.lat_vaddr = req_in.vaddr;
					next_cur.lat_pc = req_in.next_pc;
					next_cur.lat_cause = found_cause;
					next_cur.st = exc_entry_pkg::ST_SAVE;
				end
			end
			exc_entry_pkg::ST_SAVE: begin
				// Order of the entry actions is fixed
				if (save_regs) begin
					next_cur.estatus = cur.status;
				end
				next_cur.status[`ST_PIE] = 1'b0;
				if (save_regs) begin
					next_cur.ret_addr = cur.lat_pc;
				end
				if (MMU_ON) begin
					next_cur.status[`ST_USER] = 1'b0;
					next_cur.status[`ST_EH] = 1'b1;
				end
				if (MMU_ON && !eh && (cur.kind == exc_entry_pkg::K_FAST
						|| cur.kind == exc_entry_pkg::K_ACCESS_RIGHTS_FLAG)) begin
					next_cur.virtual_page_number = cur.lat_vaddr[31:`VA_VPN_LO];
				end
				// Flags only move for translation faults
				if (MMU_ON && (cur.kind == exc_entry_pkg::K_FAST
						|| cur.kind == exc_entry_pkg::K_DBL
						|| cur.kind == exc_entry_pkg::K_ACCESS_RIGHTS_FLAG)) begin
					if (!eh) begin
						next_cur.tlb_misc[`TM_DATA] = cur.data_side;
					end
					next_cur.tlb_misc[`TM_DBL] =
						cur.kind == exc_entry_pkg::K_DBL;
					next_cur.tlb_misc[`TM_ACCESS_RIGHTS_FLAG] =
						cur.kind == exc_entry_pkg::K_ACCESS_RIGHTS_FLAG;
					next_cur.tlb_misc[`TM_BAD] = 1'b1;
				end
				next_cur.cause = cur.lat_cause;
				next_cur.bad_addr = cur.lat_vaddr;
				next_cur.st = exc_entry_pkg::ST_VECT;
			end
			exc_entry_pkg::ST_VECT: begin
				// Handler addresses are build-time constants
				next_cur.redir = 1'b1;
				next_cur.redir_pc = (MMU_ON
					&& cur.kind == exc_entry_pkg::K_FAST)
					? FAST_VEC : GEN_VEC;
				next_cur.st = exc_entry_pkg::ST_IDLE;
			end
			default: begin
				// Illegal code, back to rest
				next_cur.st = exc_entry_pkg::ST_IDLE;
			end
		endcase
	end

	// State register, frozen while the enable is low
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cur <= '0;
			cur.st <= exc_entry_pkg::ST_IDLE;
			cur.status <= `STATUS_RST;
			cur.estatus <= `STATUS_RST;
			cur.tlb_misc <= `TLB_MISC_RST;
		end else if (ce_in) begin
			cur <= next_cur;
		end
	end

	// Outputs straight from state
	assign rd_data_out = cur.rdata;
	assign redirect_valid_out = cur.redir;
	assign redirect_pc_out = cur.redir_pc;
	assign status_out = cur.status;
	assign ret_addr_out = cur.ret_addr;
	assign cause_out = cur.cause;

	// Checks, skipped while frozen or in reset
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in || !ce_in);

	logic in_save;
	logic cache_op;
	assign in_save = cur.st == exc_entry_pkg::ST_SAVE;
	assign cache_op = req_in.acc == exc_entry_pkg::ACC_LINE_INV
		|| req_in.acc == exc_entry_pkg::ACC_LINE_WB
		|| req_in.acc == exc_entry_pkg::ACC_IDX_INV
		|| req_in.acc == exc_entry_pkg::ACC_IDX_WB;

	a_entry_order: assert property (
		accept |=> in_save ##1 cur.st == exc_entry_pkg::ST_VECT
		##1 redirect_valid_out)
		else $error("entry sequence out of order");

	a_double_miss: assert property (
		accept && !req_in.pipe_exc && miss && eh
		|=> cur.kind == exc_entry_pkg::K_DBL)
		else $error("double miss not raised");

	a_access_rights_flag_skip: assert property (
		accept && cache_op
		|=> cur.kind != exc_entry_pkg::K_ACCESS_RIGHTS_FLAG)
		else $error("cache op raised permission fault");

	a_pie_cleared: assert property (
		in_save |=> !status_out[`ST_PIE])
		else $error("interrupt enable not cleared");

	a_estatus_saved: assert property (
		in_save && save_regs
		|=> cur.estatus == $past(cur.status))
		else $error("status not saved");

	a_estatus_kept: assert property (
		in_save && !save_regs && !wr_in
		|=> $stable(cur.estatus) && $stable(cur.ret_addr))
		else $error("saved registers overwritten");

	a_ret_loaded: assert property (
		in_save && save_regs
		|=> ret_addr_out == $past(cur.lat_pc))
		else $error("return address not loaded");

	a_mode_flag: assert property (
		in_save && MMU_ON
		|=> !status_out[`ST_USER] && status_out[`ST_EH])
		else $error("mode or handling flag wrong");

	a_vector_pick: assert property (
		redirect_valid_out |-> (redirect_pc_out == FAST_VEC)
		== (MMU_ON && cur.kind == exc_entry_pkg::K_FAST))
		else $error("wrong handler address");

	a_vpn_record: assert property (
		in_save && MMU_ON && !eh
		&& cur.kind == exc_entry_pkg::K_ACCESS_RIGHTS_FLAG
		|=> cur.virtual_page_number == $past(cur.lat_vaddr[31:`VA_VPN_LO]))
		else $error("page number not recorded");

	a_fast_kind: assert property (
		accept && !req_in.pipe_exc && miss && !eh
		|=> cur.kind == exc_entry_pkg::K_FAST)
		else $error("fast miss not raised");

	a_dbl_side: assert property (
		accept && !req_in.pipe_exc && miss && eh && !fetch
		|=> cur.lat_cause == $past(codes_in.dbl_d))
		else $error("double miss side wrong");

	// Software write in the same step would mask the kept side bit
	a_dbl_flags: assert property (
		in_save && MMU_ON && eh && !wr_in
		&& cur.kind == exc_entry_pkg::K_DBL
		|=> cur.tlb_misc[`TM_DBL] && $stable(cur.tlb_misc[`TM_DATA]))
		else $error("double miss flags wrong");

	a_access_rights_flag_raised: assert property (
		accept && MMU_ON && !req_in.pipe_exc && req_in.tlb_match
		&& !req_in.tlb_access_rights_flag_ok && (fetch || load || store)
		|=> cur.kind == exc_entry_pkg::K_ACCESS_RIGHTS_FLAG)
		else $error("permission fault not raised");

	a_access_rights_flag_write: assert property (
		accept && !req_in.pipe_exc && access_rights_flag && store
		|=> cur.lat_cause == $past(codes_in.access_rights_flag_w))
		else $error("write class not reported");

	a_region_fault: assert property (
		accept && !req_in.pipe_exc && MPU_ON && !MMU_ON
		&& mem_acc && !req_in.mpu_match
		|=> cur.kind == exc_entry_pkg::K_MPU)
		else $error("region fault not raised");

	a_region_side: assert property (
		accept && !req_in.pipe_exc && mpu_viol && fetch
		|=> cur.lat_cause == $past(codes_in.mpu_i))
		else $error("region side wrong");

	a_flag_set: assert property (
		in_save && MMU_ON && !eh
		|=> status_out[`ST_EH])
		else $error("handling flag not set");

	a_dbl_vector: assert property (
		redirect_valid_out && cur.kind == exc_entry_pkg::K_DBL
		|-> redirect_pc_out == GEN_VEC)
		else $error("double miss not sent to general vector");

	a_vector_fixed: assert property (
		redirect_valid_out
		|-> redirect_pc_out == GEN_VEC || redirect_pc_out == FAST_VEC)
		else $error("handler address not a build constant");

	a_pipe_first: assert property (
		accept && req_in.pipe_exc
		|=> cur.kind == exc_entry_pkg::K_PIPE
		&& cur.lat_cause == $past(req_in.pipe_cause))
		else $error("pipeline fault not taken first");

	c_fast_miss: cover property (
		redirect_valid_out && redirect_pc_out == FAST_VEC);
	c_double_miss: cover property (
		redirect_valid_out && cur.kind == exc_entry_pkg::K_DBL);
	c_access_rights_flag_fault: cover property (
		redirect_valid_out && cur.kind == exc_entry_pkg::K_ACCESS_RIGHTS_FLAG);
	c_region_fault: cover property (
		redirect_valid_out && cur.kind == exc_entry_pkg::K_MPU);

endmodule : exc_entry

// ---- pipe_model.sv ----
// Pipeline and lookup side model that issues one exception request at a time
`timescale 1ns/10ps

module pipe_model (
	// Clock
	input wire logic mclk_in,
	// Control from the bench
	input wire logic go_in,
	input exc_entry_pkg::exc_req_t cmd_in,
	input wire logic ready_in,
	// Request toward the entry block
	output exc_entry_pkg::exc_req_t req_out
);
	initial req_out = '0;

	// One-cycle request, offered only while the entry block is idle
	always @(posedge mclk_in) begin : drive_blk
		exc_entry_pkg::exc_req_t t;
		t = ~req_out;
		t.valid = 1'b0;
		if (go_in && ready_in) begin
			t = cmd_in;
		end
		// Released fields flip so stale lookup results never look current
		req_out <= t;
	end
endmodule : pipe_model

// ---- tb_top.sv ----
// Self-checking bench for exception entry with and without translation
`timescale 1ns/10ps

module tb_top;
	localparam logic [31:0] GV = 32'h0000_0040;
	localparam logic [31:0] FV = 32'h0000_0180;
	localparam logic [31:0] F = 32'hffff_ffff;
	logic mclk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic go = 1'b0;
	logic ce = 1'b1;
	exc_entry_pkg::exc_req_t cmd = '0;
	exc_entry_pkg::exc_req_t req;
	exc_entry_pkg::exc_req_t pr;
	exc_entry_pkg::cause_codes_t codes = {5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
	exc_entry_pkg::access_t pacc [3] = '{exc_entry_pkg::ACC_FETCH, exc_entry_pkg::ACC_LOAD, exc_entry_pkg::ACC_STORE};
	exc_entry_pkg::access_t cacc [4] = '{exc_entry_pkg::ACC_LINE_INV, exc_entry_pkg::ACC_LINE_WB,
		exc_entry_pkg::ACC_IDX_INV, exc_entry_pkg::ACC_IDX_WB};
	logic [4:0] pcode [3];
	logic [31:0] m_rd, p_rd, m_pc, p_pc, m_ret, p_ret;
	logic [2:0] m_st, p_st;
	logic [4:0] m_cs, p_cs;
	logic m_rdy, p_rdy, m_rv, p_rv;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	int i;

	// Core clock, 100 ns
	always #50 mclk_in = ~mclk_in;

	// Translation build and protection build see the same traffic
	exc_entry #(.MMU_ON(1'b1), .MPU_ON(1'b0), .GEN_VEC(GV), .FAST_VEC(FV)) i_dut (.mclk_in(mclk_in), .ce_in(ce),
		.rst_b_in(rst_b_in), .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(m_rd),
		.req_in(req), .codes_in(codes), .entry_ready_out(m_rdy), .redirect_valid_out(m_rv),
		.redirect_pc_out(m_pc), .status_out(m_st), .ret_addr_out(m_ret), .cause_out(m_cs));
	exc_entry #(.MMU_ON(1'b0), .MPU_ON(1'b1), .GEN_VEC(GV), .FAST_VEC(FV)) i_mpu (.mclk_in(mclk_in), .ce_in(ce),
		.rst_b_in(rst_b_in), .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(p_rd),
		.req_in(req), .codes_in(codes), .entry_ready_out(p_rdy), .redirect_valid_out(p_rv),
		.redirect_pc_out(p_pc), .status_out(p_st), .ret_addr_out(p_ret), .cause_out(p_cs));
	pipe_model i_pipe (.mclk_in(mclk_in), .go_in(go), .cmd_in(cmd), .ready_in(m_rdy & p_rdy), .req_out(req));

	task test_done;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done

	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task rd_reg(input logic mpu, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		@(posedge mclk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		@(negedge mclk_in);
		check((mpu ? p_rd : m_rd) & mask, exp);
	endtask : rd_reg

	function automatic exc_entry_pkg::exc_req_t mk(input exc_entry_pkg::access_t acc, input logic [31:0] va,
		input logic tm, input logic tp, input logic mm, input logic mp);
		mk = '0;
		mk.valid = 1'b1;
		mk.acc = acc;
		mk.vaddr = va;
		mk.next_pc = va + 32'h4;
		mk.tlb_match = tm;
		mk.tlb_access_rights_flag_ok = tp;
		mk.mpu_match = mm;
		mk.mpu_access_rights_flag_ok = mp;
	endfunction : mk

	// One request; hit says whether a redirect must follow, mpu which build takes it
	task send(input exc_entry_pkg::exc_req_t r, input logic hit, input logic mpu, input logic [31:0] vec,
		input logic [4:0] cs, input logic [2:0] st);
		logic seen;
		seen = 1'b0;
		@(posedge mclk_in);
		cmd <= r;
		go <= 1'b1;
		@(posedge mclk_in);
		go <= 1'b0;
		for (int k = 0; k < 8 && !seen; k++) begin
			@(negedge mclk_in);
			seen = m_rv | p_rv;
			if (k == 1 && hit) check({31'h0, m_rdy & p_rdy}, 32'h0); // Busy while saving
		end
		check({31'h0, seen}, {31'h0, hit});
		if (hit) begin
			check({31'h0, m_rdy & p_rdy}, 32'h1); // Ready again beside the pulse
			check({31'h0, p_rv}, {31'h0, mpu});
			check(mpu ? p_pc : m_pc, vec); // Vector fixed at build
			check({27'h0, mpu ? p_cs : m_cs}, {27'h0, cs}); // Cause code
			check({29'h0, mpu ? p_st : m_st}, {29'h0, st}); // Status after entry
		end
	endtask : send

	// Hang guard, far above the expected run
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			test_done;
		end
	end

	// Main sequence
	initial begin
		pcode = '{codes.access_rights_flag_x, codes.access_rights_flag_r, codes.access_rights_flag_w};
		repeat (10) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		rd_reg(1'b0, 8'h00, F, 32'h0);
		wr_reg(8'h00, 32'h3);
		send(mk(pacc[0], 32'h1234_5678, 1'b0, 1'b1, 1'b1, 1'b1), 1'b1, 1'b0, FV, codes.fast_i, 3'h4);
		check(m_ret, 32'h1234_567c); // Return address
		rd_reg(1'b0, 8'h04, F, 32'h3); // Saved status
		rd_reg(1'b0, 8'h0c, F, 32'h0004_8d14); // Page number
		rd_reg(1'b0, 8'h10, 32'h7, 32'h0); // Flags
		wr_reg(8'h00, 32'h7);
		send(mk(pacc[1], 32'hab00_0010, 1'b0, 1'b1, 1'b1, 1'b1), 1'b1, 1'b0, GV, codes.dbl_d, 3'h4);
		check(m_ret, 32'h1234_567c); // Return address kept
		rd_reg(1'b0, 8'h04, F, 32'h3); // Saved status kept
		rd_reg(1'b0, 8'h10, 32'h7, 32'h2); // Second miss, side kept
		send(mk(pacc[0], 32'h0000_2000, 1'b0, 1'b1, 1'b1, 1'b1), 1'b1, 1'b0, GV, codes.dbl_i, 3'h4);
		for (i = 0; i < 3; i++) begin
			wr_reg(8'h00, 32'h0);
			send(mk(pacc[i], 32'h0055_5000, 1'b1, 1'b0, 1'b1, 1'b1), 1'b1, 1'b0, GV, pcode[i], 3'h4);
			rd_reg(1'b0, 8'h0c, F, 32'h0000_1554); // Page number
			rd_reg(1'b0, 8'h10, 32'h4, 32'h4); // Rights flag
		end
		for (i = 0; i < 4; i++) begin
			send(mk(cacc[i], 32'h0055_5000, 1'b1, 1'b0, 1'b1, 1'b1), 1'b0, 1'b0, GV, 5'h0, 3'h0); // Cache ops
		end
		wr_reg(8'h00, 32'h0);
		send(mk(cacc[1], 32'h0066_6000, 1'b0, 1'b1, 1'b1, 1'b1), 1'b1, 1'b0, FV, codes.fast_d, 3'h4);
		rd_reg(1'b0, 8'h10, 32'h1, 32'h1); // Data side flag
		rd_reg(1'b0, 8'h1c, F, 32'h0);
		wr_reg(8'h14, F);
		rd_reg(1'b0, 8'h14, F, {27'h0, codes.fast_d}); // Cause not writable
		wr_reg(8'h00, 32'h3);
		send(mk(pacc[0], 32'h0000_4000, 1'b1, 1'b1, 1'b0, 1'b1), 1'b1, 1'b1, GV, codes.mpu_i, 3'h2);
		check(p_ret, 32'h0000_4004); // Return address
		rd_reg(1'b1, 8'h04, F, 32'h3); // Saved status
		wr_reg(8'h00, 32'h5);
		send(mk(pacc[2], 32'h0000_8000, 1'b1, 1'b1, 1'b1, 1'b0), 1'b1, 1'b1, GV, codes.mpu_d, 3'h4);
		rd_reg(1'b1, 8'h04, F, 32'h5); // Copied without translation
		check(p_ret, 32'h0000_8004); // Return address
		wr_reg(8'h00, 32'h3);
		pr = mk(exc_entry_pkg::ACC_NONE, 32'h0000_9000, 1'b1, 1'b1, 1'b1, 1'b1);
		pr.pipe_exc = 1'b1;
		pr.pipe_cause = 5'h1f;
		send(pr, 1'b1, 1'b1, GV, 5'h1f, 3'h2); // Unknown code reaches general handler
		check(m_pc, GV);
		check({27'h0, m_cs}, 32'h0000_001f); // Unknown cause passed on
		check({29'h0, m_st}, 32'h0000_0004);
		check(m_ret, 32'h0000_9004);
		// Enable low: the write must be lost
		ce <= 1'b0;
		wr_reg(8'h00, 32'h1);
		ce <= 1'b1;
		rd_reg(1'b0, 8'h00, F, 32'h4); // Status unchanged while frozen
		test_done;
	end
endmodule : tb_top
